// file: rtl/hss_spi_status_readback.sv
// Serial return path: shift register, message latch and readback mux.
// Serial pins are sampled by i_clk; sclk must be well below 25 MHz.
`timescale 1ns/1ns
module hss_spi_status_readback
    import hss_pkg::*;
(
    input  wire logic          i_clk,
    input  wire logic          i_reset_n,
    input  wire logic          i_cs_n,
    input  wire logic          i_sclk,
    input  wire logic          i_sdi,
    input  wire hss_fault_type i_fault_0,
    input  wire hss_fault_type i_fault_1,
    input  wire logic          i_fault_latched,
    input  wire hss_pins_type  i_pins,
    input  wire logic          i_failsafe_state_out0,
    input  wire logic          i_failsafe_state_out1,
    input  wire logic          i_watchdog_expired_flag,
    input  wire logic          i_direct_on,
    output logic               o_sdo,
    output logic               o_sdo_oe_n,
    output logic               o_fault_indicator_pin,
    output logic               o_msg_valid,
    output logic [7:0]         o_msg
);

    logic [1:0] cs_sync, sclk_sync, sdi_sync;
    logic [4:0] pins_sync1, pins_sync2;
    logic       cs_d, sclk_d;
    logic       cs_fall, cs_rise, sclk_rise, sclk_fall;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cs_sync    <= 2'h3;
            sclk_sync  <= 2'h0;
            sdi_sync   <= 2'h0;
            pins_sync1 <= 5'h00;
            pins_sync2 <= 5'h00;
            cs_d       <= 1'b1;
            sclk_d     <= 1'b0;
        end else begin
            cs_sync    <= {cs_sync[0], i_cs_n};
            sclk_sync  <= {sclk_sync[0], i_sclk};
            sdi_sync   <= {sdi_sync[0], i_sdi};
            pins_sync1 <= {i_pins, i_direct_on};
            pins_sync2 <= pins_sync1;
            cs_d       <= cs_sync[1];
            sclk_d     <= sclk_sync[1];
        end
    end

    assign cs_fall   = cs_d && !cs_sync[1];
    assign cs_rise   = !cs_d && cs_sync[1];
    assign sclk_rise = !cs_sync[1] && !sclk_d && sclk_sync[1];
    assign sclk_fall = !cs_sync[1] && sclk_d && !sclk_sync[1];

    hss_pins_type pins_live;
    logic         direct_on_sync;
    assign pins_live      = hss_pins_type'(pins_sync2[4:1]);
    assign direct_on_sync = pins_sync2[0];

    // Configuration registers, one copy per output where selectable
    logic [2:0] status_select_reg;
    logic       prior_select_field;
    logic [1:0] serial_on_cmd, sense_enable;
    logic [3:0] overcurrent_level_reg [2];
    logic [3:0] blanking_openload_reg [2];
    logic [3:0] input_control_reg [2];
    logic [2:0] turn_on_delay_reg;
    logic [1:0] watchdog_period_reg;
    logic [1:0] supply_protect_reg;
    logic       summary_fault;

    // Shift path
    logic [7:0] rx_shift, tx_shift;
    logic [7:0] bit_cnt;
    logic       past_eight;
    logic [7:0] return_byte;
    logic       out_sel;

    assign out_sel = prior_select_field;

    always_comb begin
        return_byte = 8'h00;
        return_byte[7] = prior_select_field;
        unique case (status_select_reg)
            3'h0: begin
                return_byte[6:1] = out_sel ? i_fault_1 : i_fault_0;
                return_byte[0]   = summary_fault;
            end
            3'h1: begin
                return_byte[6:0] = {3'h1, sense_enable[1],
                    serial_on_cmd[1], sense_enable[0],
                    serial_on_cmd[0]};
            end
            3'h2: return_byte[6:0] =
                {3'h2, overcurrent_level_reg[out_sel]};
            3'h3: return_byte[6:0] =
                {3'h3, blanking_openload_reg[out_sel]};
            3'h4: return_byte[6:0] =
                {3'h4, input_control_reg[out_sel]};
            3'h5: begin
                if (!out_sel)
                    return_byte[6:0] = {3'h5, i_failsafe_state_out0,
                        turn_on_delay_reg};
                else
                    return_byte[6:0] = {3'h5, i_failsafe_state_out1,
                        i_watchdog_expired_flag,
                        watchdog_period_reg};
            end
            3'h6: begin
                if (!out_sel)
                    return_byte[6:0] = {3'h6, pins_live};
                else
                    return_byte[6:0] = {5'h18, supply_protect_reg};
            end
            3'h7: return_byte[6:0] = 7'h00;
        endcase
    end

    logic [7:0] echo_fifo;
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rx_shift   <= 8'h00;
            tx_shift   <= 8'h00;
            bit_cnt    <= 8'h00;
            o_sdo      <= 1'b0;
            o_sdo_oe_n <= 1'b1;
            past_eight <= 1'b0;
            echo_fifo  <= 8'h00;
        end else if (cs_fall) begin
            tx_shift   <= return_byte;
            o_sdo      <= return_byte[7];
            o_sdo_oe_n <= 1'b0;
            bit_cnt    <= 8'h00;
            past_eight <= 1'b0;
        end else if (cs_rise) begin
            o_sdo_oe_n <= 1'b1;
        end else if (sclk_rise) begin
            rx_shift  <= {rx_shift[6:0], sdi_sync[1]};
            echo_fifo <= {echo_fifo[6:0], sdi_sync[1]};
            bit_cnt   <= bit_cnt + 8'h01;
        end else if (sclk_fall) begin
            // Eight-bit delay line gives echo of the input stream
            if (bit_cnt[2:0] == 3'h0 && bit_cnt != 8'h00)
                past_eight <= 1'b1;
            tx_shift <= {tx_shift[6:0], 1'b0};
            if (past_eight || (bit_cnt[2:0] == 3'h0 && bit_cnt != 8'h00))
                o_sdo <= echo_fifo[7];
            else
                o_sdo <= tx_shift[6];
        end
    end

    // Length checked on rise; only the last byte of a chain is ours
    logic msg_ok;
    assign msg_ok = cs_rise && bit_cnt != 8'h00 &&
        (bit_cnt[2:0] & BIT_CNT_MASK) == 3'h0;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_msg_valid <= 1'b0;
            o_msg       <= 8'h00;
        end else begin
            o_msg_valid <= msg_ok;
            if (msg_ok)
                o_msg <= rx_shift;
        end
    end

    logic [3:0] addr;
    assign addr = {rx_shift[7] & rx_shift[6], rx_shift[6:4]};

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            status_select_reg        <= SEL_RESET;
            prior_select_field       <= 1'b0;
            serial_on_cmd            <= 2'h0;
            sense_enable             <= 2'h0;
            overcurrent_level_reg[0] <= 4'h0;
            overcurrent_level_reg[1] <= 4'h0;
            blanking_openload_reg[0] <= 4'h0;
            blanking_openload_reg[1] <= 4'h0;
            input_control_reg[0]     <= 4'h0;
            input_control_reg[1]     <= 4'h0;
            turn_on_delay_reg        <= 3'h0;
            watchdog_period_reg      <= 2'h0;
            supply_protect_reg       <= 2'h0;
        end else if (msg_ok) begin
            prior_select_field <= rx_shift[7];
            unique case (rx_shift[6:4])
                ADDR_STATUS_SEL[2:0]:
                    status_select_reg <= rx_shift[2:0];
                ADDR_OUT_CTRL[2:0]: begin
                    serial_on_cmd[rx_shift[7]] <= rx_shift[0];
                    sense_enable[rx_shift[7]]  <= rx_shift[3];
                end
                ADDR_OC_LEVEL[2:0]:
                    overcurrent_level_reg[rx_shift[7]] <= rx_shift[3:0];
                ADDR_BLANKING[2:0]:
                    blanking_openload_reg[rx_shift[7]] <= rx_shift[3:0];
                ADDR_INPUT_CTRL[2:0]:
                    input_control_reg[rx_shift[7]] <= rx_shift[3:0];
                ADDR_TURN_DELAY[2:0]: begin
                    if (addr == ADDR_WATCHDOG)
                        watchdog_period_reg <= rx_shift[1:0];
                    else
                        turn_on_delay_reg <= rx_shift[2:0];
                end
                3'h6: begin
                    if (addr == ADDR_SUPPLY)
                        supply_protect_reg <= rx_shift[1:0];
                end
                3'h7: ;
            endcase
        end
    end

    // Summary fault: set wins over clear-on-read
    logic any_fault, read_fault, switch_on;
    assign any_fault  = |{i_fault_0, i_fault_1};
    assign read_fault = cs_fall && status_select_reg == 3'h0;
    assign switch_on  = (msg_ok && rx_shift[6:4] == ADDR_OUT_CTRL[2:0]
        && rx_shift[0]) || direct_on_sync;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n)
            summary_fault <= 1'b0;
        else if (any_fault)
            summary_fault <= 1'b1;
        else if (read_fault)
            summary_fault <= 1'b0;
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n)
            o_fault_indicator_pin <= 1'b0;
        else if (any_fault)
            o_fault_indicator_pin <= 1'b1;
        else if (!i_fault_latched || switch_on)
            o_fault_indicator_pin <= 1'b0;
    end

    // Assertions: frame boundaries and the eighth falling clock edge
    sequence frame_open_s;
        cs_fall;
    endsequence

    sequence frame_close_ok_s;
        cs_rise && bit_cnt != 8'h00 && bit_cnt[2:0] == 3'h0;
    endsequence

    sequence frame_close_bad_s;
        cs_rise && bit_cnt[2:0] != 3'h0;
    endsequence

    // Last bit of the return byte has gone; the echo follows
    sequence eighth_fall_s;
        sclk_fall && bit_cnt[2:0] == 3'h0 && bit_cnt != 8'h00;
    endsequence

    load_on_fall_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        frame_open_s |=> !o_sdo_oe_n && o_sdo == $past(return_byte[7])
            && tx_shift == $past(return_byte))
        else $error("Return byte not loaded");

    shift_msb_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        sclk_fall && !past_eight && bit_cnt[2:0] != 3'h0
            |=> o_sdo == $past(tx_shift[6]))
        else $error("Return bit out of order");

    tristate_rise_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        cs_rise |=> o_sdo_oe_n)
        else $error("Output not released");

    length_check_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        frame_close_bad_s |=> !o_msg_valid)
        else $error("Bad length accepted");

    length_accept_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        frame_close_ok_s |=> o_msg_valid && o_msg == $past(rx_shift))
        else $error("Whole-byte message not latched");

    invalid_hold_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        !msg_ok |=> $stable(status_select_reg)
            && $stable(prior_select_field)
            && $stable(turn_on_delay_reg)
            && $stable(watchdog_period_reg)
            && $stable(supply_protect_reg))
        else $error("State changed without message");

    bit7_track_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        msg_ok |=> prior_select_field == $past(rx_shift[7]))
        else $error("Bit7 not toggle bit");

    select_hold_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        msg_ok && rx_shift[6:4] == ADDR_STATUS_SEL[2:0]
            |=> status_select_reg == $past(rx_shift[2:0]))
        else $error("Selection not taken");

    sel_code_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        status_select_reg != 3'h0 && status_select_reg != SEL_RESET
            |-> return_byte[6:4] == status_select_reg)
        else $error("Selection code not echoed");

    fault_mux_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        frame_open_s ##0 (status_select_reg == 3'h0 && !out_sel)
            |=> tx_shift[6:1] == $past(i_fault_0))
        else $error("Output 0 fault flags not returned");

    null_data_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        frame_open_s ##0 (status_select_reg == SEL_RESET)
            |=> tx_shift[2:0] == 3'h0)
        else $error("Null data wrong");

    fault_set_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        any_fault |=> summary_fault && o_fault_indicator_pin)
        else $error("Fault not flagged");

    fault_clear_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        frame_open_s ##0 (status_select_reg == 3'h0 && !any_fault)
            |=> !summary_fault)
        else $error("Summary fault not cleared by read");

    pin_hold_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        o_fault_indicator_pin && i_fault_latched && !switch_on
            |=> o_fault_indicator_pin)
        else $error("Latched fault pin dropped early");

    pin_release_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        switch_on && !any_fault |=> !o_fault_indicator_pin)
        else $error("Fault pin not reset by switch-on");

    echo_first_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        eighth_fall_s |=> o_sdo == $past(echo_fifo[7]))
        else $error("Echo does not start after eight bits");

    echo_hold_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        sclk_fall && past_eight |=> o_sdo == $past(echo_fifo[7]))
        else $error("Echo wrong");

endmodule : hss_spi_status_readback

// file: rtl/hss_pkg.sv
// Package for the serial return path of a dual high-side switch.
// Assumes one system clock; serial pins arrive asynchronously.
//
// Overview of operation
// - Chip select low loads return byte, MSB first
// - Bits after eight echo received serial input
// - Latch message only on multiple of eight
// - Chip select high tristates output; summary fault clears at chip select low when selection is 000 and no fault is present
// - Invalid length changes no configuration register
// - Return bit7 is previous toggle, selects output
// - Status selection holds until next select write
// - Selection 000 returns selected output fault flags
// - Summary fault set by any, cleared on read
// - Fault pin holds latched faults until switch-on
// - Selection 001 returns sense enables, on-commands
// - Selection 010 returns overcurrent levels
// - Selection 011 returns blanking, timeout, openload disables
// - Selection 100 returns input control settings
// - Selection 101/0 returns delay code, failsafe0
// - Selection 101/1 returns watchdog code, expired, failsafe1
// - Selection 110/0 returns live input pin levels
// - Selection 110/1 returns supply protect disables
// - Selection 111 returns null data
package hss_pkg;

    localparam logic [3:0] ADDR_STATUS_SEL  = 4'h0;
    localparam logic [3:0] ADDR_OUT_CTRL    = 4'h1;
    localparam logic [3:0] ADDR_OC_LEVEL    = 4'h2;
    localparam logic [3:0] ADDR_BLANKING    = 4'h3;
    localparam logic [3:0] ADDR_INPUT_CTRL  = 4'h4;
    localparam logic [3:0] ADDR_TURN_DELAY  = 4'h5;
    localparam logic [3:0] ADDR_WATCHDOG    = 4'hD;
    localparam logic [3:0] ADDR_SUPPLY      = 4'hE;
    localparam logic [2:0] SEL_RESET        = 3'h7;
    localparam logic [2:0] BIT_CNT_MASK     = 3'h7;

    typedef struct packed {
        logic overtemp_flag;
        logic high_overcurrent_flag;
        logic low_overcurrent_flag;
        logic open_load_flag;
        logic undervoltage_flag;
        logic overvoltage_flag;
    } hss_fault_type;

    typedef struct packed {
        logic input_1;
        logic input_0;
        logic failsafe_input;
        logic wake_input;
    } hss_pins_type;

endpackage : hss_pkg

// file: test/hss_host_model.sv
// Host model: serial bus master driving one frame per call of xfer.
// Assumes frames are started on a falling edge of the system clock.
`timescale 1ns/1ns
module hss_host_model (
    input  wire logic i_clk,
    input  wire logic i_sdo,
    input  wire logic i_sdo_oe_n,
    output logic      o_cs_n,
    output logic      o_sclk,
    output logic      o_sdi
);
    // Half of the 160 ns link period, counted in system clocks
    localparam int HALF = 8;

    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_sdi  = 1'b0;
    end

    // A released output reads inverted, so a floating line cannot match
    task automatic xfer(input int n, input logic [15:0] d,
                        output logic [15:0] r);
        r = '0;
        @(negedge i_clk);
        o_cs_n = 1'b0;
        repeat (HALF) @(negedge i_clk);
        for (int i = n - 1; i >= 0; i--) begin
            o_sdi = d[i];
            repeat (HALF) @(negedge i_clk);
            o_sclk = 1'b1;
            r = {r[14:0], i_sdo_oe_n ? ~i_sdo : i_sdo};
            repeat (HALF) @(negedge i_clk);
            o_sclk = 1'b0;
        end
        repeat (HALF) @(negedge i_clk);
        o_cs_n = 1'b1;
        // Released line stops showing the last bit
        o_sdi  = ~o_sdi;
    endtask : xfer
endmodule : hss_host_model

// file: test/testbench.sv
// Bench for the serial return path: random and corner frames.
// Assumes the host model drives the serial pins.
`timescale 1ns/1ns
module testbench;
    import hss_pkg::*;
    logic          clk, rst_n, cs_n, sclk, sdi, sdo, oe_n, fpin, mv;
    logic          flat, don, fs0, fs1, wdx;
    hss_fault_type f0, f1;
    hss_pins_type  pins;
    logic [7:0]    msg, lastmsg, b;
    logic [15:0]   r;
    logic [3:0]    v;
    logic [2:0]    d3;
    logic [1:0]    p;
    int            n_errors, n_compared, n_valid, cyc;

    hss_spi_status_readback dut (
        .i_clk(clk), .i_reset_n(rst_n), .i_cs_n(cs_n), .i_sclk(sclk),
        .i_sdi(sdi), .i_fault_0(f0), .i_fault_1(f1),
        .i_fault_latched(flat), .i_pins(pins),
        .i_failsafe_state_out0(fs0), .i_failsafe_state_out1(fs1),
        .i_watchdog_expired_flag(wdx), .i_direct_on(don), .o_sdo(sdo),
        .o_sdo_oe_n(oe_n), .o_fault_indicator_pin(fpin),
        .o_msg_valid(mv), .o_msg(msg));

    hss_host_model host (
        .i_clk(clk), .i_sdo(sdo), .i_sdo_oe_n(oe_n),
        .o_cs_n(cs_n), .o_sclk(sclk), .o_sdi(sdi));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic stop_test;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : stop_test

    // Whole run is about 6.4k cycles
    always @(posedge clk) begin
        cyc++;
        if (mv === 1'b1) begin
            n_valid++;
            lastmsg = msg;
        end
        if (cyc == 60000) begin
            n_errors++;
            stop_test();
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    function automatic logic [7:0] sc(input logic s, input logic [2:0] q);
        return {s, ADDR_STATUS_SEL[2:0], 1'b0, q};
    endfunction : sc

    // Select a readback source, then fetch it with a second frame
    task automatic readback(input logic s, input logic [2:0] q);
        frame(8, sc(s, q));
        frame(8, sc(s, q));
    endtask : readback

    task automatic frame(input int n, input logic [15:0] d);
        int k;
        k = n_valid;
        host.xfer(n, d, r);
        repeat (10) @(negedge clk);
        check(16'(oe_n), 16'h0001);
        check(16'(n_valid - k), (n % 8 == 0) ? 16'h1 : 16'h0);
        if (n % 8 == 0) check(16'(lastmsg), 16'(d[7:0]));
    endtask : frame

    initial begin
        void'($urandom(21));
        rst_n = 1'b0;
        flat = 1'b0;
        don = 1'b0;
        f0 = '0;
        f1 = '0;
        {pins, fs0, fs1, wdx} = 7'($urandom);
        n_errors = 0;
        n_compared = 0;
        n_valid = 0;
        cyc = 0;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (6) @(negedge clk);
        // First reply after power-up or reset is thrown away
        frame(8, 16'h0060);
        frame(8, sc(1'b0, 3'h6));
        check(16'(r[2:0]), 16'h0000);
        for (int i = 0; i < 4; i++) begin
            pins = 4'($urandom);
            frame(8, sc(1'b0, 3'h6));
            check(r[7:0], {1'b0, 3'h6, pins});
        end
        for (int s = 0; s < 2; s++) begin
            v = 4'($urandom);
            frame(8, {s[0], ADDR_OC_LEVEL[2:0], v});
            frame(8, sc(s[0], 3'h2));
            frame(8, sc(s[0], 3'h2));
            check(r[7:0], {s[0], 3'h2, v});
        end
        for (int k = 0; k < 2; k++)
            frame(k ? 12 : 7, {4'h5, sc(1'b0, 3'h6)});
        frame(8, sc(1'b1, 3'h2));
        check(r[7:0], {1'b1, 3'h2, v});
        b = 8'($urandom);
        frame(16, {b, sc(1'b1, 3'h2)});
        check(r, {1'b1, 3'h2, v, b});
        f0 = hss_fault_type'(6'($urandom) | 6'h20);
        f1 = hss_fault_type'(6'($urandom) | 6'h01);
        for (int s = 0; s < 2; s++) begin
            frame(8, sc(s[0], 3'h0));
            frame(8, sc(s[0], 3'h0));
            check(r[7:0], {s[0], s ? f1 : f0, 1'b1});
        end
        f0 = '0;
        f1 = '0;
        frame(8, sc(1'b0, 3'h0));
        check(16'(r[0]), 16'h0001);
        frame(8, sc(1'b0, 3'h0));
        check(16'(r[7:0]), 16'h0000);
        p = 2'($urandom);
        frame(8, {1'b1, ADDR_WATCHDOG[2:0], 2'b00, p});
        frame(8, sc(1'b1, 3'h5));
        frame(8, sc(1'b1, 3'h5));
        check(r[7:0], {1'b1, 3'h5, fs1, wdx, p});
        d3 = 3'($urandom);
        frame(8, {1'b0, ADDR_TURN_DELAY[2:0], 1'b0, d3});
        frame(8, sc(1'b0, 3'h5));
        frame(8, sc(1'b0, 3'h5));
        check(r[7:0], {1'b0, 3'h5, fs0, d3});
        v = 4'($urandom);
        frame(8, {1'b1, ADDR_BLANKING[2:0], v});
        readback(1'b1, 3'h3);
        check(r[7:0], {1'b1, 3'h3, v});
        v = 4'($urandom);
        frame(8, {1'b0, ADDR_INPUT_CTRL[2:0], v});
        readback(1'b0, 3'h4);
        check(r[7:0], {1'b0, 3'h4, v});
        v = 4'($urandom);
        frame(8, {1'b1, ADDR_OUT_CTRL[2:0], v});
        readback(1'b0, 3'h1);
        check(r[7:0], {1'b0, 3'h1, v[3], v[0], 2'b00});
        p = 2'($urandom);
        frame(8, {1'b1, ADDR_SUPPLY[2:0], 2'b00, p});
        readback(1'b1, 3'h6);
        check(r[7:0], {1'b1, 3'h6, 2'b00, p});
        f0 = hss_fault_type'(6'h10);
        flat = 1'b1;
        repeat (10) @(negedge clk);
        check(16'(fpin), 16'h0001);
        f0 = '0;
        repeat (10) @(negedge clk);
        check(16'(fpin), 16'h0001);
        don = 1'b1;
        repeat (10) @(negedge clk);
        don = 1'b0;
        repeat (10) @(negedge clk);
        check(16'(fpin), 16'h0000);
        stop_test();
    end
endmodule : testbench
